// ==== verilog/acs_top.sv ====
// Purpose : Conversion sequencer of a 24-bit sigma-delta converter
// Assumes : Modulator sample arrives on sample_in; AHB-Lite single word access
// Notes   : Serial link pins are sampled by hclk; framing lies elsewhere
// Behaviour
// - Three-bit gain field picks six ranges
// - Code step equals range over two^24
// - Temperature select gives 14-bit left-justified value
// - Negative temperature is inverted plus one
// - Chop: normal then reversed, averaged
// - Chop continuous: first slow, then half-time
// - Reset loads defaults, enters power-down
// - Mode one single-shot, zero continuous
// - Trigger powers up, self-clears, converts once
// - Trigger during conversion is ignored
// - Continuous stores result, restarts immediately
// - Three or four wire serial link
// - Ready pin driven low on new data
// - Results clip at full-scale codes
`timescale 1ns/1ps
module acs_top (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic [31:0]       hrdata,
  output logic              hreadyout,
  output logic              hresp,
  input  wire logic         serial_cs_n,
  input  wire logic         serial_clk,
  input  wire logic [24:0]  sample_in,
  input  wire logic [13:0]  temp_in,
  output logic              serial_out_ready_pin,
  output logic              serial_out_ready_oe,
  output logic              mod_power_up,
  output logic              mod_polarity_rev,
  output logic              mod_temp_sel,
  output logic [2:0]        mod_input_pair,
  output logic [2:0]        mod_gain,
  output logic              irq
);
  import acs_pkg::*;
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [31:0] ctrl;
    logic [23:0] result;
    logic [1:0]  irq_st;
    logic [1:0]  irq_mask;
    acs_state_t  fsm;
    logic        second;
    logic        primed;
    logic [15:0] run_cnt;
    logic [24:0] first_smp;
    logic        ready_n;
    logic        oe;
    logic        irq;
    logic        pol;
    logic        start;
    logic        ap_wr;
    logic        ap_rd;
    logic [7:0]  ap_addr;
    logic [31:0] rdata;
  } acs_top_t;
  acs_top_t   st_r, st_nxt;
  acs_conv_if cif ();
  logic       cs_sel_s;
  logic       sclk_s;
  logic       sclk_d_r;
  // Select is synchronised active high so the flops' reset level means deselected
  acs_sync2 u_cs (.hclk(hclk), .hresetn(hresetn), .d(~serial_cs_n), .q(cs_sel_s));
  acs_sync2 u_ck (.hclk(hclk), .hresetn(hresetn), .d(serial_clk), .q(sclk_s));
  acs_conv_timer u_tmr (.hclk(hclk), .hresetn(hresetn), .cif(cif));
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sclk_d_r <= 1'b0;
    end else begin
      sclk_d_r <= sclk_s;
    end
  end
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Saturate a 25-bit signed sum to 24-bit two's complement
  function automatic logic [23:0] acs_clip(input logic [24:0] v);
    if (!v[24] && v[23]) begin
      acs_clip = ACS_POS_FS;
    end else if (v[24] && !v[23]) begin
      acs_clip = ACS_NEG_FS;
    end else begin
      acs_clip = v[23:0];
    end
  endfunction
  // Step size in picovolts, FSR over 2^24 (full span 2*FS)
  function automatic logic [31:0] acs_lsb_pv(input logic [2:0] g);
    case (g)
      3'h0:    acs_lsb_pv = 32'h000B_2B60;
      3'h1:    acs_lsb_pv = 32'h0007_7240;
      3'h2:    acs_lsb_pv = 32'h0003_B920;
      3'h3:    acs_lsb_pv = 32'h0001_DC90;
      3'h4:    acs_lsb_pv = 32'h0000_EE48;
      default: acs_lsb_pv = 32'h0000_7724;
    endcase
  endfunction
  logic [2:0]  gain_range_sel;
  logic        temp_sense_select;
  logic        chop_en;
  logic        single_mode;
  logic [24:0] avg_sum;
  logic [24:0] this_smp;
  logic [15:0] temp_word;
  logic        ss_req;
  logic        wr_ctrl;
  logic        cs_active;
  assign gain_range_sel    = (st_r.ctrl[ACS_GAIN_LO +: 3] > ACS_GAIN_MAX) ?
                             ACS_GAIN_MAX : st_r.ctrl[ACS_GAIN_LO +: 3];
  assign temp_sense_select = st_r.ctrl[ACS_TS_BIT];
  assign chop_en           = st_r.ctrl[ACS_CHOP_BIT];
  assign single_mode       = st_r.ctrl[ACS_MODE_BIT];
  // Temperature: 14-bit two's complement placed in bits 15:2
  assign temp_word = {temp_in, 2'b00};
  // Reversed polarity sample is negated before averaging
  assign this_smp  = st_r.pol ? (~sample_in + 25'h000_0001) : sample_in;
  assign avg_sum   = {st_r.first_smp[24], st_r.first_smp[24:1]} +
                     {this_smp[24], this_smp[24:1]};
  assign wr_ctrl   = st_r.ap_wr && (st_r.ap_addr == ACS_OFS_CTRL);
  assign ss_req    = wr_ctrl && hwdata[ACS_SS_BIT];
  assign cs_active = cs_sel_s;
  assign cif.cycles = 16'(ACS_CONV_CYC);
  assign cif.start  = st_r.start;
  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt        = st_r;
    st_nxt.start  = 1'b0;
    st_nxt.ap_wr  = 1'b0;
    st_nxt.ap_rd  = 1'b0;
    // Register writes; trigger bit never stored as one
    if (wr_ctrl) begin
      st_nxt.ctrl = hwdata & 32'h0000_073F;
    end
    st_nxt.ctrl[ACS_SS_BIT] = 1'b0;
    if (st_r.ap_wr && st_r.ap_addr == ACS_OFS_MASK) begin
      st_nxt.irq_mask = hwdata[1:0];
    end
    if (st_r.ap_wr && st_r.ap_addr == ACS_OFS_IRQ) begin
      st_nxt.irq_st = st_r.irq_st & ~hwdata[1:0];
    end
    // A host read of the result retires the ready indication
    if (st_r.ap_rd && st_r.ap_addr == ACS_OFS_RESULT) begin
      st_nxt.ready_n = 1'b1;
    end
    case (st_r.fsm)
      ACS_PWRDN: begin
        st_nxt.primed = 1'b0;
        st_nxt.second = 1'b0;
        st_nxt.pol    = 1'b0;
        if (wr_ctrl && !hwdata[ACS_MODE_BIT]) begin
          st_nxt.fsm   = ACS_CONV;
          st_nxt.start = 1'b1;
        end else if (single_mode && ss_req) begin
          st_nxt.fsm   = ACS_CONV;
          st_nxt.start = 1'b1;
        end
      end
      ACS_CONV: begin
        // Trigger writes here fall through with no effect
        if (cif.done) begin
          if (chop_en && !st_r.second && !st_r.primed) begin
            st_nxt.first_smp = this_smp;
            st_nxt.second    = 1'b1;
            st_nxt.pol       = ~st_r.pol;
            st_nxt.start     = 1'b1;
          end else begin
            if (temp_sense_select) begin
              st_nxt.result = {{8{temp_word[15]}}, temp_word};
            end else if (chop_en) begin
              st_nxt.result = acs_clip(avg_sum);
            end else begin
              st_nxt.result = acs_clip(sample_in);
            end
            st_nxt.ready_n          = 1'b0;
            st_nxt.irq_st[ACS_IRQ_DONE] = 1'b1;
            if (!temp_sense_select && (sample_in[24] != sample_in[23])) begin
              st_nxt.irq_st[ACS_IRQ_CLIP] = 1'b1;
            end
            // Chop pairs slide in continuous mode: each new half, of either polarity, reuses the last
            st_nxt.first_smp = this_smp;
            st_nxt.primed    = chop_en;
            st_nxt.second    = 1'b0;
            // Leaving for power-down must not raise the reversed polarity
            st_nxt.pol       = (chop_en && !single_mode) ? ~st_r.pol : 1'b0;
            if (single_mode) begin
              st_nxt.fsm = ACS_PWRDN;
            end else begin
              st_nxt.start = 1'b1;
            end
          end
        end
      end
      default: begin
        st_nxt.fsm = ACS_PWRDN;
      end
    endcase
    // Pin goes high a fixed lead before each new result in continuous mode,
    // so an unread result still stays flagged for most of the next conversion
    if (st_r.start) begin
      st_nxt.run_cnt = 16'h0000;
    end else if (st_r.fsm == ACS_CONV) begin
      st_nxt.run_cnt = st_r.run_cnt + 16'h0001;
    end
    if (!single_mode && st_r.fsm == ACS_CONV &&
        st_r.run_cnt == 16'(ACS_CONV_CYC - ACS_RDY_LEAD_CYC)) begin
      st_nxt.ready_n = 1'b1;
    end
    st_nxt.oe  = cs_active;
    st_nxt.irq = |(st_nxt.irq_st & st_nxt.irq_mask);
    // Bus address phase
    if (hsel && hready && htrans[1]) begin
      st_nxt.ap_wr   = hwrite;
      st_nxt.ap_rd   = !hwrite;
      st_nxt.ap_addr = haddr[7:0];
      case (haddr[7:0])
        ACS_OFS_CTRL:   st_nxt.rdata = st_r.ctrl;
        ACS_OFS_STATUS: st_nxt.rdata = {27'h0, sclk_s & ~sclk_d_r, cs_active,
                                        st_r.ready_n, st_r.fsm == ACS_CONV,
                                        st_r.second};
        ACS_OFS_RESULT: st_nxt.rdata = {8'h00, st_r.result};
        ACS_OFS_IRQ:    st_nxt.rdata = {30'h0, st_r.irq_st};
        ACS_OFS_MASK:   st_nxt.rdata = {30'h0, st_r.irq_mask};
        ACS_OFS_LSB:    st_nxt.rdata = acs_lsb_pv(gain_range_sel);
        default:        st_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r         <= '0;
      st_r.ctrl    <= ACS_CTRL_RST;
      st_r.fsm     <= ACS_PWRDN;
      st_r.ready_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end
  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign hrdata               = st_r.rdata;
  assign hreadyout            = 1'b1;
  assign hresp                = 1'b0;
  assign serial_out_ready_pin = st_r.ready_n;
  assign serial_out_ready_oe  = st_r.oe;
  assign mod_power_up         = (st_r.fsm == ACS_CONV);
  assign mod_polarity_rev     = st_r.pol;
  assign mod_temp_sel         = st_r.ctrl[ACS_TS_BIT];
  assign mod_input_pair       = st_r.ctrl[ACS_MUX_LO +: 3];
  assign mod_gain             = st_r.ctrl[ACS_GAIN_LO +: 3];
  assign irq                  = st_r.irq;
endmodule

// ==== pkg/acs_pkg.sv ====
// Purpose : Shared constants and types for the ADC conversion sequencer
// Assumes : 100 MHz hclk, AHB-Lite register access
// Notes   : Modulator is modelled by a sample port and a cycle count
package acs_pkg;
  localparam logic [7:0]  ACS_OFS_CTRL    = 8'h00;
  localparam logic [7:0]  ACS_OFS_STATUS  = 8'h04;
  localparam logic [7:0]  ACS_OFS_RESULT  = 8'h08;
  localparam logic [7:0]  ACS_OFS_IRQ     = 8'h0C;
  localparam logic [7:0]  ACS_OFS_MASK    = 8'h10;
  localparam logic [7:0]  ACS_OFS_LSB     = 8'h14;
  // Control word fields
  localparam int          ACS_GAIN_LO     = 0;
  localparam int          ACS_TS_BIT      = 3;
  localparam int          ACS_CHOP_BIT    = 4;
  localparam int          ACS_MODE_BIT    = 5;
  localparam int          ACS_SS_BIT      = 6;
  localparam int          ACS_MUX_LO      = 8;
  localparam logic [31:0] ACS_CTRL_RST    = 32'h0000_0020;
  // Gain range codes 0..5 valid; 6,7 read back the narrowest step but reach mod_gain unchanged
  localparam logic [2:0]  ACS_GAIN_MAX    = 3'h5;
  // Irq bits
  localparam int          ACS_IRQ_DONE    = 0;
  localparam int          ACS_IRQ_CLIP    = 1;
  // Timing
  localparam int          ACS_CLK_MHZ     = 100;
  localparam int          ACS_CONV_US     = 20;
  localparam int          ACS_CONV_CYC    = ACS_CONV_US * ACS_CLK_MHZ;
  // Continuous mode: ready pin returns high this long before the next result
  localparam int          ACS_RDY_LEAD_US  = 8;
  localparam int          ACS_RDY_LEAD_CYC = ACS_RDY_LEAD_US * ACS_CLK_MHZ;
  localparam logic [23:0] ACS_POS_FS      = 24'h7F_FFFF;
  localparam logic [23:0] ACS_NEG_FS      = 24'h80_0000;
  typedef enum logic [1:0] {ACS_PWRDN, ACS_CONV} acs_state_t;
endpackage

// ==== pkg/acs_conv_if.sv ====
// Purpose : Carries a finished conversion between the timer and the top
// Assumes : One hclk domain
// Notes   : done is a one-cycle pulse
`timescale 1ns/1ps
interface acs_conv_if;
  logic        start;
  logic        done;
  logic [15:0] cycles;
  modport ctrl (output start, output cycles, input done);
  modport tmr  (input start, input cycles, output done);
endinterface

// ==== verilog/acs_conv_timer.sv ====
// Purpose : Times one internal modulator conversion
// Assumes : start only while idle
// Notes   : Stands in for the sigma-delta settle time
`timescale 1ns/1ps
module acs_conv_timer (
  input  wire logic  hclk,
  input  wire logic  hresetn,
  acs_conv_if.tmr    cif
);
  import acs_pkg::*;
  typedef struct packed {
    logic        busy;
    logic [15:0] cnt;
    logic        done;
  } acs_tmr_t;
  acs_tmr_t st_r, st_nxt;
  always_comb begin
    st_nxt      = st_r;
    st_nxt.done = 1'b0;
    if (st_r.busy) begin
      if (st_r.cnt <= 16'h0001) begin
        st_nxt.busy = 1'b0;
        st_nxt.done = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt - 16'h0001;
      end
    end else if (cif.start) begin
      st_nxt.busy = 1'b1;
      st_nxt.cnt  = cif.cycles;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign cif.done = st_r.done;
endmodule

// ==== verilog/acs_sync2.sv ====
// Purpose : Two-flop synchroniser for a pin level
// Assumes : Destination is hclk
// Notes   : First stage is read only by the second
`timescale 1ns/1ps
module acs_sync2 (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic d,
  output logic      q
);
  logic meta_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_r <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// ==== bench/acs_top_assertions.sv ====
// Purpose: Port checks for the conversion sequencer
// Assumes: One hclk domain, acs_pkg constants
// Notes  : Control fields are expected two cycles after the data phase
`timescale 1ns/1ps
module acs_top_assertions
  import acs_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        serial_cs_n,
  input wire logic        serial_out_ready_pin,
  input wire logic        serial_out_ready_oe,
  input wire logic        mod_power_up,
  input wire logic        mod_polarity_rev,
  input wire logic        mod_temp_sel,
  input wire logic [2:0]  mod_input_pair,
  input wire logic [2:0]  mod_gain
);
  logic        taken;
  logic        wr_ctrl_r;
  logic [31:0] wd_r;
  logic [15:0] up_cnt_r;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  assign taken = hsel && hready && htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ctrl_r <= 1'b0;
      wd_r      <= '0;
      up_cnt_r  <= '0;
    end else begin
      wr_ctrl_r <= taken && hwrite && haddr == {24'h00_0000, ACS_OFS_CTRL};
      wd_r      <= wr_ctrl_r ? hwdata : wd_r;
      up_cnt_r  <= mod_power_up ? up_cnt_r + 16'h0001 : 16'h0000;
    end
  end
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_rdata_holds: assert property (!taken |=> $stable(hrdata))
    else $error("read data moved without a request");
  a_ctrl_fields: assert property (wr_ctrl_r |-> ##2
    {mod_input_pair, mod_temp_sel, mod_gain} == {wd_r[10:8], wd_r[3], wd_r[2:0]})
    else $error("control fields differ from written word");
  a_oe_on_cs: assert property (!serial_cs_n [*4] |-> serial_out_ready_oe)
    else $error("pin not driven while selected");
  a_oe_off_cs: assert property (serial_cs_n [*4] |-> !serial_out_ready_oe)
    else $error("pin driven while deselected");
  a_ready_cause: assert property ($fell(serial_out_ready_pin) |->
    $past(mod_power_up) || $past(mod_power_up, 2))
    else $error("new data flagged without a conversion");
  a_rev_when_up: assert property ($rose(mod_polarity_rev) |-> mod_power_up)
    else $error("reversed half outside a conversion");
  a_conv_length: assert property ($fell(mod_power_up) |-> up_cnt_r >= ACS_CONV_CYC)
    else $error("conversion ended too soon");
endmodule
bind acs_top acs_top_assertions u_acs_top_assertions (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .serial_cs_n(serial_cs_n), .serial_out_ready_pin(serial_out_ready_pin),
  .serial_out_ready_oe(serial_out_ready_oe), .mod_power_up(mod_power_up),
  .mod_polarity_rev(mod_polarity_rev), .mod_temp_sel(mod_temp_sel),
  .mod_input_pair(mod_input_pair), .mod_gain(mod_gain));

// ==== bench/acs_host_model.sv ====
// Purpose: Serial host that frames the link and watches the ready pin
// Assumes: Line level already resolved with the pull-up
// Notes  : Offset of 3 ns keeps link edges off the hclk edge
`timescale 1ns/1ps
module acs_host_model (
  input  wire logic line,
  output logic      cs_n,
  output logic      sclk,
  output logic      saw_new
);
  initial begin
    cs_n    = 1'b1;
    sclk    = 1'b0;
    saw_new = 1'b0;
  end
  // Clock stands low outside frames, 80 ns inside
  task automatic frame(input int bits);
    #3;
    cs_n = 1'b0;
    #500;
    saw_new = !line;
    repeat (bits) begin
      sclk = 1'b1;
      #40;
      sclk = 1'b0;
      #40;
    end
    cs_n = 1'b1;
  endtask
endmodule

// ==== bench/tb_acs_top.sv ====
// Purpose: Self-checking bench for acs_top over AHB-Lite
// Assumes: Host model on the serial pins
// Notes  : Modulator input is negated in the reversed chop half
`timescale 1ns/1ps
module tb_acs_top;
  import acs_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq, saw_new, line;
  logic        serial_cs_n, serial_clk, serial_out_ready_pin, serial_out_ready_oe;
  logic        mod_power_up, mod_polarity_rev, mod_temp_sel;
  logic [1:0]  htrans;
  logic [2:0]  hsize, mod_input_pair, mod_gain;
  logic [13:0] temp_in;
  logic [24:0] sample_in, smp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int          fails, n_compared, c1, c2;
  logic [24:0] t_s [5] = '{25'h080_0000, 25'h17F_FFFF, 25'h001_2345, 25'h0, 25'h0};
  logic [13:0] t_t [5] = '{14'h0, 14'h0, 14'h0, 14'h3CE0, 14'h0C80};
  logic [7:0]  t_c [5] = '{8'h60, 8'h60, 8'h60, 8'h68, 8'h68};
  logic [23:0] t_e [5] = '{24'h7F_FFFF, 24'h80_0000, 24'h01_2345, 24'hFF_F380, 24'h00_3200};
  // Step sizes in picovolts, widest range first
  logic [31:0] t_l [6] = '{32'h000B_2B60, 32'h0007_7240, 32'h0003_B920,
                           32'h0001_DC90, 32'h0000_EE48, 32'h0000_7724};
  assign hready = hreadyout;
  // Weak pull-up holds the line high when released
  assign line = serial_out_ready_oe ? serial_out_ready_pin : 1'b1;
  acs_top u_acs_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .serial_cs_n(serial_cs_n),
    .serial_clk(serial_clk), .sample_in(sample_in), .temp_in(temp_in),
    .serial_out_ready_pin(serial_out_ready_pin), .serial_out_ready_oe(serial_out_ready_oe),
    .mod_power_up(mod_power_up), .mod_polarity_rev(mod_polarity_rev),
    .mod_temp_sel(mod_temp_sel), .mod_input_pair(mod_input_pair), .mod_gain(mod_gain),
    .irq(irq));
  acs_host_model u_acs_host_model (.line(line), .cs_n(serial_cs_n), .sclk(serial_clk),
    .saw_new(saw_new));
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) sample_in <= mod_polarity_rev ? -smp : smp;
  // ----
  // Tasks
  // ----
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic stop();
    fails++;
    print_verdict();
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic chkb(input string s, input logic e, input logic g);
    chk(s, {31'h0, e}, {31'h0, g});
  endtask
  task automatic edge_rdy();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 20);
    if (hreadyout !== 1'b1) stop();
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h00_0000, a};
    hwrite <= w;
    edge_rdy();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    edge_rdy();
    rd = hrdata;
  endtask
  task automatic wait_new(output int c);
    c = 0;
    while (serial_out_ready_pin !== 1'b0 && c < 9000) begin
      @(posedge hclk);
      c++;
    end
    if (c >= 9000) stop();
  endtask
  task automatic shot(input logic [31:0] ctl, input logic [24:0] s, input logic [13:0] t);
    smp     <= s;
    temp_in <= t;
    bus(1'b1, ACS_OFS_CTRL, ctl);
    wait_new(c1);
    bus(1'b0, ACS_OFS_RESULT, '0);
  endtask
  // ----
  // Sequence
  // ----
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, smp, temp_in} = '0;
    hsize = 3'h2;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, ACS_OFS_CTRL, '0);
    chk("ctrl reset", ACS_CTRL_RST, rd);
    chkb("pin reset", 1'b1, serial_out_ready_pin);
    chkb("power reset", 1'b0, mod_power_up);
    bus(1'b0, 8'h20, '0);
    chk("unmapped", 32'h0, rd);
    for (int g = 0; g < 6; g++) begin
      bus(1'b1, ACS_OFS_CTRL, 32'h20 | g);
      repeat (3) @(posedge hclk);
      chk("gain", 32'(g), {29'h0, mod_gain});
      bus(1'b0, ACS_OFS_LSB, '0);
      chk("lsb size", t_l[g], rd);
    end
    $display("test reset and gain done");
    bus(1'b1, ACS_OFS_MASK, 32'h1);
    smp <= 25'h000_1234;
    bus(1'b1, ACS_OFS_CTRL, 32'h360);
    bus(1'b1, ACS_OFS_CTRL, 32'h360);
    wait_new(c1);
    repeat (3) @(posedge hclk);
    chkb("irq done", 1'b1, irq);
    chkb("power down", 1'b0, mod_power_up);
    bus(1'b0, ACS_OFS_CTRL, '0);
    chk("trigger clear", 32'h320, rd);
    bus(1'b0, ACS_OFS_RESULT, '0);
    chk("result", 32'h1234, rd & 32'h00FF_FFFF);
    repeat (60) @(posedge hclk);
    chkb("pin after read", 1'b1, serial_out_ready_pin);
    chkb("no queued conv", 1'b0, mod_power_up);
    bus(1'b1, ACS_OFS_IRQ, 32'h1);
    repeat (3) @(posedge hclk);
    chkb("irq clear", 1'b0, irq);
    bus(1'b1, ACS_OFS_MASK, 32'h0);
    for (int i = 0; i < 5; i++) begin
      shot({24'h0, t_c[i]}, t_s[i], t_t[i]);
      chk("result", {8'h0, t_e[i]}, rd & 32'h00FF_FFFF);
      chkb("irq masked", 1'b0, irq);
    end
    $display("test single shot done");
    shot(32'h70, 25'h000_0100, 14'h0);
    chk("chop result", 32'h100, rd & 32'h00FF_FFFF);
    chkb("chop two convs", 1'b1, c1 >= 2 * ACS_CONV_CYC);
    bus(1'b1, ACS_OFS_CTRL, 32'h10);
    wait_new(c1);
    bus(1'b0, ACS_OFS_RESULT, '0);
    chk("cont result", 32'h100, rd & 32'h00FF_FFFF);
    repeat (2) @(posedge hclk);
    wait_new(c2);
    chkb("first slow", 1'b1, c1 >= 2 * ACS_CONV_CYC);
    chkb("later half", 1'b1, c2 >= ACS_CONV_CYC - 60 && c2 <= ACS_CONV_CYC + 10);
    repeat (100) @(posedge hclk);
    chkb("pin held low", 1'b0, serial_out_ready_pin);
    bus(1'b1, ACS_OFS_CTRL, 32'h30);
    for (c1 = 0; mod_power_up !== 1'b0 && c1 < 9000; c1++) @(posedge hclk);
    if (c1 >= 9000) stop();
    repeat (100) @(posedge hclk);
    chkb("cont stopped", 1'b0, mod_power_up);
    $display("test chop and continuous done");
    // Retire the last continuous result so the wait below sees a fresh one
    bus(1'b0, ACS_OFS_RESULT, '0);
    bus(1'b1, ACS_OFS_CTRL, 32'h60);
    wait_new(c1);
    chkb("oe idle", 1'b0, serial_out_ready_oe);
    fork
      u_acs_host_model.frame(24);
      begin
        repeat (60) @(posedge hclk);
        bus(1'b0, ACS_OFS_STATUS, '0);
      end
    join
    chkb("saw ready", 1'b1, saw_new);
    chk("cs active", 32'h8, rd & 32'h8);
    repeat (5) @(posedge hclk);
    chkb("oe released", 1'b0, serial_out_ready_oe);
    $display("test serial link done");
    print_verdict();
  end
endmodule
